//--- uvep_pkg.sv
// package: timing constants, pin widths and states for the eprom host controller
package uvep_pkg;

    // ------------------------------------------------------------
    // clock and widths
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 8000;
    localparam int ADDR_W        = 20;
    localparam int DATA_W        = 16;
    localparam int CNT_W         = 12;

    // ------------------------------------------------------------
    // read timing, slow grade (covers both grades)
    // ------------------------------------------------------------
    localparam int T_ACC_NS     = 120;
    localparam int T_OE_NS      = 60;
    localparam int T_DF_NS      = 50;
    localparam int T_VERIFY_NS  = 120;
    localparam int T_BYTE_ST_NS = 120;

    // ------------------------------------------------------------
    // programming timing
    // ------------------------------------------------------------
    localparam int T_SETUP_NS   = 2000;
    localparam int T_HOLD_NS    = 2000;
    localparam int T_PW_MIN_NS  = 9500;
    localparam int T_PW_MAX_NS  = 10500;
    localparam int T_PW_NOM_NS  = 10000;

    // least times round up, longest round down
    localparam int CYC_ACC    = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_OE     = (T_OE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_DF     = (T_DF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_VERIFY = (T_VERIFY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_BYTE   = (T_BYTE_ST_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_SETUP  = (T_SETUP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_HOLD   = (T_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_PW_MIN = (T_PW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CYC_PW_MAX = (T_PW_MAX_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYC_PW     = (T_PW_NOM_NS * 1000) / CLK_PERIOD_PS;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = '0;
    localparam logic [DATA_W-1:0] DATA_RST = '0;

    // ------------------------------------------------------------
    // commands and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {UVEP_CMD_READ, UVEP_CMD_PROG, UVEP_CMD_IDENT} uvep_cmd_e;

    typedef enum logic [3:0] {
        UVEP_IDLE, UVEP_RD_SETUP, UVEP_RD_ACC, UVEP_RD_DONE, UVEP_PG_SETUP,
        UVEP_PG_PULSE, UVEP_PG_HOLD, UVEP_VF_ACC, UVEP_RELEASE
    } uvep_state_e;

endpackage : uvep_pkg

//--- uvep_cycle_timer.sv
// file: down-counter that times every phase of a pin cycle except the single-clock UVEP_RD_SETUP and UVEP_RD_DONE steps
`timescale 1ns/1ps
module uvep_cycle_timer
    import uvep_pkg::*;
(
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             rst_n_i,
    // load and status
    input  wire logic             load_i,
    input  wire logic [CNT_W-1:0] value_i,
    output logic                  expired_o
);

    typedef struct packed
    {
        logic [CNT_W-1:0] count;
    } uvep_tmr_s;

    uvep_tmr_s st_ff;
    uvep_tmr_s nxt_st;

    // ------------------------------------------------------------
    // count down from a loaded figure, stop at zero
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        if (load_i)
        begin
            nxt_st.count = value_i;
        end
        else if (st_ff.count != '0)
        begin
            nxt_st.count = st_ff.count - CNT_W'(1);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // decoded from the register alone: the sequencer's load depends on
    // expiry, so folding load_i in here would close a combinational loop
    assign expired_o = (st_ff.count == '0);

endmodule : uvep_cycle_timer

//--- uvep_host.sv
// file: host controller that reads, programs and verifies the uv eprom over its pins
`timescale 1ns/1ps
module uvep_host
    import uvep_pkg::*;
(
    // clock and reset
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    // user command port
    input  wire logic              cmd_valid_i,
    input  wire logic [1:0]        cmd_op_i,
    input  wire logic              cmd_byte_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic              cmd_low_addr_i,
    input  wire logic [DATA_W-1:0] cmd_wdata_i,
    output logic                   cmd_ready_o,
    output logic                   rsp_valid_o,
    output logic [DATA_W-1:0]      rsp_rdata_o,
    output logic                   rsp_verify_ok_o,
    // eprom control pins
    output logic                   chip_en_n_o,
    output logic                   out_en_n_o,
    output logic                   width_select_o,
    output logic                   prog_supply_en_o,
    output logic                   identifier_select_voltage_o,
    output logic [ADDR_W-1:0]      addr_o,
    // eprom data pins, three signals each
    input  wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0]      data_o,
    output logic [DATA_W-1:0]      data_oe_o
);

    // ------------------------------------------------------------
    // reset release through two flops
    // ------------------------------------------------------------
    logic rst_meta_ff;
    logic rst_n_ff;

    always_ff @(posedge clk_sys_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            rst_meta_ff <= 1'b0;
            rst_n_ff    <= 1'b0;
        end
        else
        begin
            rst_meta_ff <= 1'b1;
            rst_n_ff    <= rst_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        uvep_state_e       state;
        logic              ready;
        logic              rsp_valid;
        logic [DATA_W-1:0] rdata;
        logic              verify_ok;
        logic              ce_n;
        logic              oe_n;
        logic              width;
        logic              supply;
        logic              ident;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] doe;
        logic [DATA_W-1:0] wdata;
    } uvep_host_s;

    uvep_host_s st_ff;
    uvep_host_s nxt_st;

    logic             tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic             tmr_expired;

    uvep_cycle_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rst_n_i   (rst_n_ff),
        .load_i    (tmr_load),
        .value_i   (tmr_value),
        .expired_o (tmr_expired)
    );

    // ------------------------------------------------------------
    // sequencer; slow-grade figures are used so either grade works
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st    = st_ff;
        tmr_load  = 1'b0;
        tmr_value = '0;
        nxt_st.rsp_valid = 1'b0;
        unique case (st_ff.state)
            UVEP_IDLE:
            begin
                if (cmd_valid_i && st_ff.ready)
                begin
                    nxt_st.ready = 1'b0;
                    nxt_st.wdata = cmd_wdata_i;
                    nxt_st.addr  = cmd_addr_i;
                    nxt_st.ident = 1'b0;
                    nxt_st.doe   = '0;
                    if (cmd_op_i == UVEP_CMD_PROG)
                    begin
                        // supply on, output enable high, data driven full width
                        nxt_st.supply = 1'b1;
                        nxt_st.width  = 1'b0;
                        nxt_st.oe_n   = 1'b1;
                        nxt_st.dout   = cmd_wdata_i;
                        nxt_st.doe    = '1;
                        nxt_st.state  = UVEP_PG_SETUP;
                        tmr_load  = 1'b1;
                        tmr_value = CNT_W'(CYC_SETUP);
                    end
                    else
                    begin
                        nxt_st.supply = 1'b0;
                        // identifier readout needs word width
                        nxt_st.width  = (cmd_op_i == UVEP_CMD_IDENT) || !cmd_byte_i;
                        if (cmd_op_i == UVEP_CMD_IDENT)
                        begin
                            nxt_st.ident = 1'b1;
                            nxt_st.addr  = {{(ADDR_W-1){1'b0}}, cmd_addr_i[0]};
                        end
                        else if (cmd_byte_i)
                        begin
                            // top pin becomes low address input
                            nxt_st.dout = {cmd_low_addr_i, {(DATA_W-1){1'b0}}};
                            nxt_st.doe  = {1'b1, {(DATA_W-1){1'b0}}};
                        end
                        nxt_st.state = UVEP_RD_SETUP;
                    end
                end
            end
            UVEP_RD_SETUP:
            begin
                // chip enable as select, output enable with it
                nxt_st.ce_n  = 1'b0;
                nxt_st.oe_n  = 1'b0;
                nxt_st.state = UVEP_RD_ACC;
                tmr_load  = 1'b1;
                tmr_value = CNT_W'(CYC_ACC);
            end
            UVEP_RD_ACC:
            begin
                // access time covers output-enable and width-select figures
                if (tmr_expired)
                begin
                    nxt_st.rdata = st_ff.width ? data_i
                                 : {{(DATA_W/2){1'b0}}, data_i[DATA_W/2-1:0]};
                    nxt_st.state = UVEP_RD_DONE;
                end
            end
            UVEP_RD_DONE:
            begin
                nxt_st.rsp_valid = 1'b1;
                nxt_st.verify_ok = 1'b0;
                nxt_st.ce_n      = 1'b1;
                nxt_st.oe_n      = 1'b1;
                nxt_st.state     = UVEP_RELEASE;
                tmr_load  = 1'b1;
                tmr_value = CNT_W'(CYC_DF);
            end
            UVEP_PG_SETUP:
            begin
                if (tmr_expired)
                begin
                    nxt_st.ce_n  = 1'b0;
                    nxt_st.state = UVEP_PG_PULSE;
                    tmr_load  = 1'b1;
                    tmr_value = CNT_W'(CYC_PW);
                end
            end
            UVEP_PG_PULSE:
            begin
                if (tmr_expired)
                begin
                    nxt_st.ce_n  = 1'b1;
                    nxt_st.state = UVEP_PG_HOLD;
                    tmr_load  = 1'b1;
                    tmr_value = CNT_W'(CYC_HOLD);
                end
            end
            UVEP_PG_HOLD:
            begin
                // data held then released; wait before output enable falls
                if (tmr_expired)
                begin
                    if (st_ff.doe != '0)
                    begin
                        nxt_st.doe = '0;
                        tmr_load  = 1'b1;
                        tmr_value = CNT_W'(CYC_SETUP);
                    end
                    else
                    begin
                        nxt_st.oe_n  = 1'b0;
                        nxt_st.state = UVEP_VF_ACC;
                        tmr_load  = 1'b1;
                        tmr_value = CNT_W'(CYC_VERIFY);
                    end
                end
            end
            UVEP_VF_ACC:
            begin
                if (tmr_expired)
                begin
                    nxt_st.rdata     = data_i;
                    nxt_st.verify_ok = (data_i == st_ff.wdata);
                    nxt_st.rsp_valid = 1'b1;
                    nxt_st.oe_n      = 1'b1;
                    nxt_st.state     = UVEP_RELEASE;
                    tmr_load  = 1'b1;
                    tmr_value = CNT_W'(CYC_DF);
                end
            end
            UVEP_RELEASE:
            begin
                // let the device float before anything else changes
                if (tmr_expired)
                begin
                    nxt_st.supply = 1'b0;
                    nxt_st.ident  = 1'b0;
                    nxt_st.doe    = '0;
                    nxt_st.width  = 1'b1;
                    nxt_st.ready  = 1'b1;
                    nxt_st.state  = UVEP_IDLE;
                end
            end
            default:
            begin
                nxt_st.state = UVEP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_ff)
    begin
        if (!rst_n_ff)
        begin
            st_ff       <= '0;
            st_ff.state <= UVEP_IDLE;
            st_ff.ready <= 1'b1;
            st_ff.ce_n  <= 1'b1;
            st_ff.oe_n  <= 1'b1;
            st_ff.width <= 1'b1;
            st_ff.addr  <= ADDR_RST;
            st_ff.dout  <= DATA_RST;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from the state flops
    // ------------------------------------------------------------
    assign cmd_ready_o                 = st_ff.ready;
    assign rsp_valid_o                 = st_ff.rsp_valid;
    assign rsp_rdata_o                 = st_ff.rdata;
    assign rsp_verify_ok_o             = st_ff.verify_ok;
    assign chip_en_n_o                 = st_ff.ce_n;
    assign out_en_n_o                  = st_ff.oe_n;
    assign width_select_o              = st_ff.width;
    assign prog_supply_en_o            = st_ff.supply;
    assign identifier_select_voltage_o = st_ff.ident;
    assign addr_o                      = st_ff.addr;
    assign data_o                      = st_ff.dout;
    assign data_oe_o                   = st_ff.doe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_pulse_width: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        $rose(st_ff.state == UVEP_PG_PULSE) |-> (st_ff.supply && !st_ff.ce_n)[*8])
        else $error("program pulse ended early");
    a_prog_oe_high: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        (st_ff.supply && !st_ff.ce_n) |-> st_ff.oe_n)
        else $error("output enable low during program pulse");
    a_data_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        $rose(st_ff.ce_n) && st_ff.supply |-> (st_ff.doe == '1) [*8])
        else $error("program data released too soon");
    a_verify_follows: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        $rose(st_ff.ce_n) && st_ff.supply |-> ##[1:600] !st_ff.oe_n)
        else $error("no verify read after program pulse");
    a_no_contend: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        !st_ff.oe_n |-> (st_ff.doe[DATA_W-2:0] == '0))
        else $error("host drives data while device outputs");
    a_ident_word: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        st_ff.ident |-> st_ff.width && !st_ff.supply)
        else $error("identifier mode without word width");
    a_read_wait: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        $fell(st_ff.oe_n) && !st_ff.supply |-> !st_ff.oe_n [*8])
        else $error("read ended before access time");
    a_resp_pulse: assert property (@(posedge clk_sys_i) disable iff (!rst_n_ff)
        st_ff.rsp_valid |=> !st_ff.rsp_valid && st_ff.oe_n)
        else $error("response not single pulse");

endmodule : uvep_host

//--- uvep_eprom_model.sv
// file: clockless behavioural model of the eprom as seen from its pins
`timescale 1ns/1ps
module uvep_eprom_model
    import uvep_pkg::*;
#(
    parameter int         ACC_NS     = 116,
    parameter int         OE_NS      = 56,
    parameter int         VF_NS      = 116,
    parameter int         DF_NS      = 48,
    parameter logic [7:0] MAKER_CODE = 8'h5A, // arbitrary value
    parameter logic [7:0] TYPE_CODE  = 8'hC3  // arbitrary value
)
(
    // pins driven by the host
    input  wire logic              chip_en_n_i,
    input  wire logic              out_en_n_i,
    input  wire logic              width_select_i,
    input  wire logic              prog_supply_i,
    input  wire logic              id_voltage_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] host_d_i,
    input  wire logic [DATA_W-1:0] host_oe_i,
    // resolved data wire and count of host timing breaks
    output logic [DATA_W-1:0]      bus_o,
    output int                     viol_o
);
    logic [DATA_W-1:0] mem [int];
    logic [DATA_W-1:0] dq = 16'h0000;
    wire  [DATA_W-1:0] den;
    wire               rd_late;
    realtime           t_fall, t_rise = -1.0e9, t_addr, t_data;
    wire               rd_on = !out_en_n_i && (!chip_en_n_i || prog_supply_i);
    wire               byte_md = !width_select_i && !prog_supply_i;
    initial viol_o = 0;

    // what the array would present for the current pins
    function automatic logic [DATA_W-1:0] view();
        logic [DATA_W-1:0] w;
        w = mem.exists(addr_i) ? mem[addr_i] : 16'hFFFF; // erased cells read as ones
        if (id_voltage_i)
            return addr_i[0] ? {2{TYPE_CODE}} : {2{MAKER_CODE}};
        if (byte_md)
            return {8'h00, host_d_i[15] ? w[15:8] : w[7:0]};
        return w;
    endfunction : view

    // data follows pin edges only, old value kept 5 ns then junk
    always @(chip_en_n_i, width_select_i, prog_supply_i, id_voltage_i, addr_i, host_d_i[15])
    begin
        dq <= #5 ~dq;
        dq <= #(ACC_NS) view();
    end
    always @(negedge out_en_n_i) dq <= #(prog_supply_i ? VF_NS : OE_NS) view();

    // drivers on at once, off after the disable time; the delay is inertial
    // so a release still pending cannot cut into the next read
    assign #(DF_NS) rd_late = rd_on;
    assign den = (rd_on || rd_late) ? (byte_md ? 16'h00FF : 16'hFFFF)
                                    : 16'h0000;

    // released lines show the inverse, not a stale copy
    always @*
        for (int i = 0; i < DATA_W; i++)
            bus_o[i] = host_oe_i[i] ? host_d_i[i] : (den[i] ? dq[i] : ~dq[i]);

    // ------------------------------------------------------------
    // program pulse and host timing watch
    // ------------------------------------------------------------
    always @(host_oe_i, den) if (|(host_oe_i & den)) viol_o++;
    always @(addr_i) t_addr = $realtime;
    always @(host_d_i, host_oe_i)
    begin
        if (prog_supply_i && $realtime - t_rise < 2000) viol_o++;
        t_data = $realtime;
    end
    always @(negedge out_en_n_i)
        if (prog_supply_i && $realtime - t_data < 2000) viol_o++;
    always @(negedge chip_en_n_i)
    begin
        t_fall = $realtime;
        if (prog_supply_i && (t_fall - t_addr < 2000 || t_fall - t_data < 2000)) viol_o++;
        if (id_voltage_i && (|addr_i[ADDR_W-1:1] || !width_select_i)) viol_o++;
    end
    always @(posedge chip_en_n_i)
        if (prog_supply_i && out_en_n_i)
        begin
            t_rise = $realtime;
            if (t_rise - t_fall < 9500 || t_rise - t_fall > 10500) viol_o++;
            mem[addr_i] = view() & host_d_i; // only zeros are written
        end
endmodule : uvep_eprom_model

//--- uvep_host_tb_top.sv
// file: self-checking testbench for the eprom host controller
`timescale 1ns/1ps
module uvep_host_tb_top;
    import uvep_pkg::*;
    localparam logic [7:0] MAKER = 8'h5A; // arbitrary value
    localparam logic [7:0] DTYPE = 8'hC3; // arbitrary value
    logic              clk_sys_i, reset_n_i, cmd_valid_i, cmd_byte_i, cmd_low_addr_i;
    logic [1:0]        cmd_op_i;
    logic [ADDR_W-1:0] cmd_addr_i, addr_o;
    logic [DATA_W-1:0] cmd_wdata_i, rsp_rdata_o, data_i, data_o, data_oe_o, rd;
    logic              cmd_ready_o, rsp_valid_o, rsp_verify_ok_o, chip_en_n_o, out_en_n_o;
    logic              width_select_o, prog_supply_en_o, identifier_select_voltage_o, ok;
    int                error_cnt = 0, n_tests = 0, viol;

    uvep_host uvep_host_inst (.*);
    uvep_eprom_model #(.MAKER_CODE(MAKER), .TYPE_CODE(DTYPE)) uvep_eprom_model_inst (
        .chip_en_n_i(chip_en_n_o), .out_en_n_i(out_en_n_o), .width_select_i(width_select_o),
        .prog_supply_i(prog_supply_en_o), .id_voltage_i(identifier_select_voltage_o),
        .addr_i(addr_o), .host_d_i(data_o), .host_oe_i(data_oe_o), .bus_o(data_i),
        .viol_o(viol));

    // free-running system clock
    initial
    begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp,
                         input string what);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : step

    // waits for ready, then holds the request across the taking edge
    task automatic issue(input logic [1:0] op, input logic byt, input logic [ADDR_W-1:0] a,
                         input logic low, input logic [DATA_W-1:0] wd);
        for (int n = 0; n < 100 && cmd_ready_o !== 1'b1; n++)
            step(1);
        {cmd_op_i, cmd_byte_i, cmd_addr_i, cmd_low_addr_i, cmd_wdata_i} = {op, byt, a, low, wd};
        cmd_valid_i = 1'b1;
        step(1);
        cmd_valid_i = 1'b0;
    endtask : issue

    task automatic wait_rsp();
        for (int n = 0; n < 3000 && rsp_valid_o !== 1'b1; n++)
            step(1);
        check({15'h0, rsp_valid_o}, 16'h1, "answer pulse");
        rd = rsp_rdata_o;
        ok = rsp_verify_ok_o;
        step(1);
        check({15'h0, rsp_valid_o}, 16'h0, "answer pulse length");
    endtask : wait_rsp

    task automatic test_done();
        $display("Comparisons: %0d, mismatches: %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : test_done

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        check({9'h0, cmd_ready_o, chip_en_n_o, out_en_n_o, width_select_o, prog_supply_en_o,
               identifier_select_voltage_o, rsp_valid_o}, 16'h0078, "reset pins");
        check(data_oe_o, 16'h0000, "reset data drive");
    endtask : t_reset

    // read, byte read or identifier read, pins looked at mid-access
    task automatic t_read(input logic [1:0] op, input logic byt, input logic [ADDR_W-1:0] a,
                          input logic low, input logic [DATA_W-1:0] exp);
        issue(op, byt, a, low, 16'h0);
        step(3);
        check({10'h0, chip_en_n_o, out_en_n_o, width_select_o, data_oe_o[15],
               byt & data_o[15], identifier_select_voltage_o},
              {10'h0, 2'b00, ~byt, byt, byt & low, op == UVEP_CMD_IDENT}, "read pins");
        check(addr_o[15:0], (op == UVEP_CMD_IDENT) ? {15'h0, a[0]} : a[15:0],
              "read address");
        wait_rsp();
        check(rd, exp, "read data");
    endtask : t_read

    task automatic t_program(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                             input logic [DATA_W-1:0] exp, input logic exp_ok);
        issue(UVEP_CMD_PROG, 1'b0, a, 1'b0, d);
        step(300);
        check({13'h0, chip_en_n_o, out_en_n_o, prog_supply_en_o}, 16'h0003,
              "program pins");
        wait_rsp();
        check(rd, exp, "verify data");
        check({15'h0, ok}, {15'h0, exp_ok}, "verify flag");
    endtask : t_program

    // a program request while busy must be dropped
    task automatic t_refused();
        issue(UVEP_CMD_READ, 1'b0, 20'h00010, 1'b0, 16'h0);
        step(1);
        {cmd_op_i, cmd_addr_i, cmd_wdata_i} = {UVEP_CMD_PROG, 20'h00020, 16'h0000};
        cmd_valid_i = 1'b1;
        step(4);
        cmd_valid_i = 1'b0;
        wait_rsp();
        check(rd, 16'h1234, "read beside refused command");
        t_read(UVEP_CMD_READ, 1'b0, 20'h00020, 1'b0, 16'hFFFF);
    endtask : t_refused

    // watchdog, about five times the expected run
    initial
    begin
        step(30000);
        error_cnt++;
        $display("BAD at %0t: run did not finish", $time);
        test_done();
    end

    // main sequence
    initial
    begin
        reset_n_i = 1'b0;
        {cmd_valid_i, cmd_op_i, cmd_byte_i, cmd_addr_i, cmd_low_addr_i, cmd_wdata_i} = '0;
        step(15);
        t_reset();
        step(1);
        reset_n_i = 1'b1;
        step(3);
        t_read(UVEP_CMD_READ, 1'b0, 20'h00010, 1'b0, 16'hFFFF);
        t_program(20'h00010, 16'h1234, 16'h1234, 1'b1);
        t_program(20'hFFFFF, 16'h0F0F, 16'h0F0F, 1'b1);
        t_program(20'hFFFFF, 16'h00FF, 16'h000F, 1'b0);
        t_read(UVEP_CMD_READ, 1'b0, 20'h00010, 1'b0, 16'h1234);
        t_read(UVEP_CMD_READ, 1'b1, 20'h00010, 1'b0, 16'h0034);
        t_read(UVEP_CMD_READ, 1'b1, 20'h00010, 1'b1, 16'h0012);
        t_read(UVEP_CMD_READ, 1'b0, 20'hFFFFF, 1'b0, 16'h000F);
        t_read(UVEP_CMD_IDENT, 1'b0, 20'hABCD0, 1'b0, {2{MAKER}});
        t_read(UVEP_CMD_IDENT, 1'b0, 20'hABCD1, 1'b0, {2{DTYPE}});
        t_refused();
        step(20);
        check(viol[15:0], 16'h0000, "pin timing breaks seen by device");
        test_done();
    end
endmodule : uvep_host_tb_top
